// ===== hbp_cfg.svh
/*
 * Constants of the 8-bit host byte port: register offsets, control bit positions,
 * select codes, reset values and timing counts.
 * Assumes inclusion by bare name from the bench and the port module.
 */
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH

// Core address of the shared control register.
`define HBP_CTRL_ADDR      16'h002c
// Control register bit positions.
`define HBP_BIT_BOB        0
`define HBP_BIT_CORE_IRQ   2
`define HBP_BIT_HOST_IRQ   3
// Control register reset value.
`define HBP_CTRL_RESET     16'h0000
// Register-select codes.
`define HBP_SEL_CTRL       2'h0
`define HBP_SEL_DATA_INC   2'h1
`define HBP_SEL_ADDR       2'h2
`define HBP_SEL_DATA       2'h3
// Wait count loaded when a strobe is taken; ready stays low for this count plus one cycle.
`define HBP_WAIT_CYCLES    4'h3

`endif

// ===== hbp_host_model.sv
/* Host processor model driving the byte port's pins one byte at a time.
   Assumes the bench calls xfer and ties the unused strobes itself. */
module hbp_host_model (
	// Clock and device answers.
	input  wire logic       clock_i,
	input  wire logic       host_ready_out_o,
	input  wire logic       host_byte_bus_oe_o,
	input  wire logic [7:0] host_byte_bus_o,
	// Host pins.
	output logic            host_chip_select_n_i,
	output logic            data_strobe_a_n_i,
	output logic            host_read_write_i,
	output logic            byte_ident_in_i,
	output logic            reg_select_lo_i,
	output logic            reg_select_hi_i,
	output logic      [7:0] host_byte_bus_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drive_q;
	logic [7:0] byte_q;
	// The device wins the bus; a released bus shows the inverse of the last byte.
	assign host_byte_bus_i = host_byte_bus_oe_o ? host_byte_bus_o : (drive_q ? byte_q : ~byte_q);
	// Idle pins at time zero.
	initial begin
		{host_chip_select_n_i, data_strobe_a_n_i, host_read_write_i} = 3'h7;
		{byte_ident_in_i, reg_select_hi_i, reg_select_lo_i, drive_q} = 4'h0;
		byte_q = 8'h00;
	end
	// One byte: strobe held 8 cycles, then until ready, then a gap of 6.
	task automatic xfer(input logic rd, input logic [1:0] sel, input logic bil, input logic [7:0] wd,
		output logic [7:0] rv, output logic ok);
		int n;
		@(posedge clock_i);
		host_chip_select_n_i <= 1'b0;
		data_strobe_a_n_i <= 1'b0;
		host_read_write_i <= rd;
		byte_ident_in_i <= bil;
		{reg_select_hi_i, reg_select_lo_i} <= sel;
		drive_q <= !rd;
		byte_q <= wd;
		n = 0;
		repeat (8) @(posedge clock_i);
		while (!host_ready_out_o && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		ok = host_ready_out_o;
		rv = host_byte_bus_i;
		data_strobe_a_n_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		host_chip_select_n_i <= 1'b1;
		drive_q <= 1'b0;
	endtask : xfer
endmodule : hbp_host_model

// ===== hbp_host_port.sv
/*
 * Host byte port: 8-bit slave through which an external host reads and writes
 * the on-chip RAM via an address pointer and data window, plus the shared control
 * register. Assumes the RAM answers ram_rdata_i one cycle after a granted read,
 * and that host pins are asynchronous to clock_i.
 */
// Summary of operation
// - 8-bit two-way bus; each 16-bit word moves as two bytes by byte ident.
// - Address pointer and data window are reachable by the host only.
// - Control register is shared; core reaches it at address 002Ch.
// - Successive host bytes are merged into 16-bit words automatically.
// - Window writes launch the RAM access by themselves on completion; window reads fetch at the first byte.
// - Host and core both reach all RAM at all times, no host-only mode.
// - Host pins are resynchronised to the core clock before arbitration.
// - The port ignores host accesses while reset is held.
// - On a same-address clash the host wins; core stalls one cycle.
// - Two select inputs choose control, pointer, or window with/without increment.
// - A control bit decides whether first or second byte is the high byte.
// - Window accesses with increment advance the pointer after each word.
// - Host writing the core request bit interrupts the core.
// - Core writing the host request bit raises the host interrupt output.
// - Host writing the host request bit clears the host interrupt output unless a core control write lands in the same cycle.
// - The address pointer holds the RAM location of the current access.
// - The window returns RAM contents on reads, carries data on writes.
// - Ready is low while the port still completes its internal access.
// - The data bus floats from the third cycle on that both data strobes or chip select are high.
`include "hbp_cfg.svh"

module hbp_host_port #(
	parameter int ADDR_W = 16
) (
	// Clock and reset.
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// Host pins.
	input  wire logic              host_chip_select_n_i,
	input  wire logic              data_strobe_a_n_i,
	input  wire logic              data_strobe_b_n_i,
	input  wire logic              addr_strobe_n_i,
	input  wire logic              host_read_write_i,
	input  wire logic              byte_ident_in_i,
	input  wire logic              reg_select_lo_i,
	input  wire logic              reg_select_hi_i,
	input  wire logic [7:0]        host_byte_bus_i,
	output logic      [7:0]        host_byte_bus_o,
	output logic                   host_byte_bus_oe_o,
	output logic                   host_ready_out_o,
	output logic                   host_irq_out_o,
	// Core register access.
	input  wire logic              core_reg_wr_i,
	input  wire logic [15:0]       core_reg_addr_i,
	input  wire logic [15:0]       core_reg_wdata_i,
	output logic      [15:0]       core_reg_rdata_o,
	output logic                   core_irq_request_o,
	// Core RAM cycle seen for arbitration.
	input  wire logic              core_ram_valid_i,
	input  wire logic [ADDR_W-1:0] core_ram_addr_i,
	output logic                   core_stall_o,
	// RAM port of the host side.
	output logic                   ram_valid_o,
	output logic                   ram_write_o,
	output logic      [ADDR_W-1:0] ram_addr_o,
	output logic      [15:0]       ram_wdata_o,
	input  wire logic [15:0]       ram_rdata_i
);
	initial begin
		if (ADDR_W < 1 || ADDR_W > 16) $error("ADDR_W must be 1 to 16");
	end

	// Two-stage synchronisers for every host pin.
	hbp_pkg::hbp_pins_t raw_w, s1_q, s2_q, s3_q;
	logic [7:0] bus1_q, bus2_q;
	assign raw_w = '{host_chip_select_n_i, data_strobe_a_n_i, data_strobe_b_n_i, addr_strobe_n_i,
			host_read_write_i, byte_ident_in_i, {reg_select_hi_i, reg_select_lo_i}};
	always_ff @(posedge clock_i) begin
		s1_q   <= raw_w;
		s2_q   <= s1_q;
		s3_q   <= s2_q;
		bus1_q <= host_byte_bus_i;
		bus2_q <= bus1_q;
	end

	// Strobe decode: active when chip select and the combined data strobe are low.
	function automatic logic active_of(input hbp_pkg::hbp_pins_t p);
		active_of = !p.chip_select_n && (p.strobe_a_n ^ p.strobe_b_n ? 1'b1 : !p.strobe_a_n);
	endfunction
	wire active_now_w  = active_of(s2_q);
	wire active_prev_w = active_of(s3_q);
	wire start_w       = active_now_w && !active_prev_w;
	wire end_w         = !active_now_w && active_prev_w;
	wire as_fall_w     = !s2_q.addr_strobe_n && s3_q.addr_strobe_n;

	// Registers and latched controls.
	logic [15:0]       ctrl_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [15:0]       wlatch_q, rlatch_q;
	logic [7:0]        first_q;
	logic              lat_rw_q, lat_bi_q, as_used_q;
	logic [1:0]        lat_sel_q;
	logic [3:0]        wait_q;
	logic              ram_pend_q, ram_wr_q, rd_fill_q, inc_after_q;
	hbp_pkg::hbp_state_t state_q;

	// Address strobe wins when used; otherwise controls latch at the first data strobe fall.
	wire       use_rw_w  = (as_used_q || as_fall_w) ? (as_fall_w ? s2_q.read_write : lat_rw_q) : s2_q.read_write;
	wire       use_bi_w  = (as_used_q || as_fall_w) ? (as_fall_w ? s2_q.byte_ident : lat_bi_q) : s2_q.byte_ident;
	wire [1:0] use_sel_w = (as_used_q || as_fall_w) ? (as_fall_w ? s2_q.reg_select : lat_sel_q) : s2_q.reg_select;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lat_rw_q  <= 1'b1;
			lat_bi_q  <= 1'b0;
			lat_sel_q <= 2'h0;
			as_used_q <= 1'b0;
		end else if (as_fall_w || start_w) begin
			lat_rw_q  <= use_rw_w;
			lat_bi_q  <= use_bi_w;
			lat_sel_q <= use_sel_w;
			as_used_q <= as_fall_w && !start_w;
		end else if (end_w) begin
			as_used_q <= 1'b0;
		end
	end

	// Access decode on the latched select.
	wire is_data_w   = lat_sel_q == `HBP_SEL_DATA || lat_sel_q == `HBP_SEL_DATA_INC;
	wire is_inc_w    = lat_sel_q == `HBP_SEL_DATA_INC;
	wire bob_w       = ctrl_q[`HBP_BIT_BOB];
	wire host_wr_w   = end_w && !lat_rw_q;
	wire second_w    = lat_bi_q;
	wire [15:0] word_w = bob_w ? {first_q, bus2_q} : {bus2_q, first_q};
	wire core_ctrl_w = core_reg_wr_i && core_reg_addr_i == `HBP_CTRL_ADDR;
	// A window read must decode the controls being taken now, not those of the last access.
	wire fetch_sel_w = use_sel_w == `HBP_SEL_DATA || use_sel_w == `HBP_SEL_DATA_INC;
	wire rd_fetch_w  = start_w && fetch_sel_w && use_rw_w && !use_bi_w;

	// Host-side registers: byte merge, pointer, window and control.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ctrl_q      <= `HBP_CTRL_RESET;
			ptr_q       <= '0;
			wlatch_q    <= 16'h0000;
			first_q     <= 8'h00;
			ram_pend_q  <= 1'b0;
			ram_wr_q    <= 1'b0;
			inc_after_q <= 1'b0;
		end else begin
			ram_pend_q <= 1'b0;
			if (host_wr_w && !second_w)
				first_q <= bus2_q;
			if (host_wr_w && second_w) begin
				unique case (lat_sel_q)
					`HBP_SEL_ADDR: ptr_q <= word_w[ADDR_W-1:0];
					`HBP_SEL_CTRL: begin
						ctrl_q[`HBP_BIT_BOB]      <= word_w[`HBP_BIT_BOB];
						ctrl_q[`HBP_BIT_CORE_IRQ] <= ctrl_q[`HBP_BIT_CORE_IRQ] | word_w[`HBP_BIT_CORE_IRQ];
						if (word_w[`HBP_BIT_HOST_IRQ] && !core_ctrl_w)
							ctrl_q[`HBP_BIT_HOST_IRQ] <= 1'b0;
					end
					default: begin
						wlatch_q   <= word_w;
						ram_pend_q <= 1'b1;
						ram_wr_q   <= 1'b1;
					end
				endcase
			end
			// Host reads of the window fetch at the first byte of each word.
			if (rd_fetch_w) begin
				ram_pend_q <= 1'b1;
				ram_wr_q   <= 1'b0;
			end
			if (end_w && is_data_w && second_w)
				inc_after_q <= is_inc_w;
			if (inc_after_q) begin
				ptr_q       <= ptr_q + 1'b1;
				inc_after_q <= 1'b0;
			end
			if (core_ctrl_w) begin
				ctrl_q[`HBP_BIT_BOB]      <= core_reg_wdata_i[`HBP_BIT_BOB];
				ctrl_q[`HBP_BIT_HOST_IRQ] <= ctrl_q[`HBP_BIT_HOST_IRQ] | core_reg_wdata_i[`HBP_BIT_HOST_IRQ];
				if (core_reg_wdata_i[`HBP_BIT_CORE_IRQ] && !(host_wr_w && second_w && lat_sel_q == `HBP_SEL_CTRL))
					ctrl_q[`HBP_BIT_CORE_IRQ] <= 1'b0;
			end
		end
	end

	// RAM cycle: granted at once, so host wins clashes and the core stalls one cycle.
	assign ram_valid_o  = ram_pend_q;
	assign ram_write_o  = ram_wr_q;
	assign ram_addr_o   = ptr_q;
	assign ram_wdata_o  = wlatch_q;
	assign core_stall_o = ram_pend_q && core_ram_valid_i && core_ram_addr_i == ptr_q;

	// Read data capture and ready timing.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rd_fill_q <= 1'b0;
			rlatch_q  <= 16'h0000;
			wait_q    <= 4'h0;
			state_q   <= hbp_pkg::HBP_IDLE;
		end else begin
			rd_fill_q <= ram_pend_q && !ram_wr_q;
			if (rd_fill_q)
				rlatch_q <= ram_rdata_i;
			unique case (state_q)
				hbp_pkg::HBP_IDLE: if (start_w) begin
					state_q <= hbp_pkg::HBP_ACTIVE;
					wait_q  <= `HBP_WAIT_CYCLES;
				end
				hbp_pkg::HBP_ACTIVE: begin
					if (wait_q != 4'h0)
						wait_q <= wait_q - 4'h1;
					else
						state_q <= hbp_pkg::HBP_RAM;
					if (end_w)
						state_q <= hbp_pkg::HBP_DONE;
				end
				hbp_pkg::HBP_RAM:  if (end_w) state_q <= hbp_pkg::HBP_DONE;
				hbp_pkg::HBP_DONE: if (!ram_pend_q && !rd_fill_q) state_q <= hbp_pkg::HBP_IDLE;
			endcase
		end
	end
	assign host_ready_out_o = !rst_i && !(state_q == hbp_pkg::HBP_ACTIVE || ram_pend_q || rd_fill_q);

	// Byte steering for host reads.
	wire [15:0] rd_word_w = (lat_sel_q == `HBP_SEL_CTRL) ? ctrl_q :
			(lat_sel_q == `HBP_SEL_ADDR) ? 16'(ptr_q) : rlatch_q;
	wire high_pick_w = bob_w ^ lat_bi_q;
	always_ff @(posedge clock_i) begin
		if (rst_i)
			host_byte_bus_o <= 8'h00;
		else
			host_byte_bus_o <= high_pick_w ? rd_word_w[15:8] : rd_word_w[7:0];
	end
	// Drive only while selected and strobed, never in reset.
	assign host_byte_bus_oe_o = !rst_i && active_now_w && active_prev_w && lat_rw_q;

	// Core side outputs.
	assign core_reg_rdata_o   = ctrl_q;
	assign core_irq_request_o = ctrl_q[`HBP_BIT_CORE_IRQ];
	assign host_irq_out_o     = ctrl_q[`HBP_BIT_HOST_IRQ];
endmodule : hbp_host_port

// ===== hbp_host_port_props.sv
/* Assertions on the pins and core-side outputs of the host byte port.
   Assumes a bind onto hbp_host_port whose port names it shares. */
module hbp_host_port_props (
	// Clock and reset.
	input wire logic        clock_i,
	input wire logic        rst_i,
	// Host pins.
	input wire logic        host_chip_select_n_i,
	input wire logic        data_strobe_a_n_i,
	input wire logic        host_read_write_i,
	input wire logic        byte_ident_in_i,
	input wire logic        reg_select_lo_i,
	input wire logic        host_byte_bus_oe_o,
	input wire logic        host_ready_out_o,
	input wire logic        host_irq_out_o,
	// Core side.
	input wire logic        core_reg_wr_i,
	input wire logic [15:0] core_reg_addr_i,
	input wire logic [15:0] core_reg_wdata_i,
	input wire logic        ram_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Window accesses that must launch a RAM cycle, and the bound on it.
	sequence win_read_s;
		$fell(data_strobe_a_n_i) && host_read_write_i && !byte_ident_in_i && reg_select_lo_i;
	endsequence
	sequence win_write_s;
		$rose(data_strobe_a_n_i) && !host_read_write_i && byte_ident_in_i && reg_select_lo_i;
	endsequence
	sequence ram_req_s;
		##[1:5] ram_valid_o;
	endsequence
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ram_valid_o && !host_irq_out_o)
		else $error("port active in reset");
	bus_float_a: assert property ((host_chip_select_n_i || data_strobe_a_n_i) [*3] |-> !host_byte_bus_oe_o)
		else $error("bus driven while idle");
	ready_wait_a: assert property ($fell(data_strobe_a_n_i) |-> ##[2:4] !host_ready_out_o [*3])
		else $error("no wait states");
	win_read_a: assert property (win_read_s and !host_chip_select_n_i |-> ram_req_s)
		else $error("window read launched no RAM read");
	win_write_a: assert property (win_write_s and !host_chip_select_n_i |-> ram_req_s)
		else $error("window write launched no RAM write");
	ram_pulse_a: assert property (ram_valid_o |=> !ram_valid_o)
		else $error("RAM request longer than a cycle");
	host_irq_set_a: assert property (core_reg_wr_i && core_reg_addr_i == 16'h002c && core_reg_wdata_i[3] |=> host_irq_out_o)
		else $error("host interrupt not raised");
	irq_cause_a: assert property ($rose(host_irq_out_o) |-> $past(core_reg_wr_i))
		else $error("host interrupt without core write");
endmodule : hbp_host_port_props

// ===== hbp_host_port_tb.sv
/* Bench for the host byte port: host model, a small RAM and a busy core.
   Assumes hbp_cfg.svh is on the include path. */
`include "hbp_cfg.svh"
module hbp_host_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        byte_order_select;
		logic [1:0]  sel;
		logic [15:0] ptr;
		logic [15:0] data;
		logic [15:0] next_ptr;
	} hbp_row_t;
	logic clock_i, rst_i, host_chip_select_n_i, data_strobe_a_n_i, data_strobe_b_n_i, addr_strobe_n_i;
	logic host_read_write_i, byte_ident_in_i, reg_select_lo_i, reg_select_hi_i, host_byte_bus_oe_o;
	logic host_ready_out_o, host_irq_out_o, core_reg_wr_i, core_irq_request_o, core_ram_valid_i;
	logic core_stall_o, ram_valid_o, ram_write_o, byte_order_select;
	logic [7:0]  host_byte_bus_i, host_byte_bus_o;
	logic [15:0] core_reg_addr_i, core_reg_wdata_i, core_reg_rdata_o, core_ram_addr_i;
	logic [15:0] ram_addr_o, ram_wdata_o, ram_rdata_i, rv;
	logic [15:0] mem [0:255];
	int          mismatches, tests_run, stalls, writes;
	hbp_row_t    rows [4];
	hbp_host_port DUT (.*);
	hbp_host_model host (.*);
	// Clock source.
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// RAM with one-cycle read data; counts writes and core stalls.
	always @(posedge clock_i) begin
		if (ram_valid_o && ram_write_o) begin
			mem[ram_addr_o[7:0]] <= ram_wdata_o;
			writes++;
		end
		ram_rdata_i <= mem[ram_addr_o[7:0]];
		if (core_stall_o === 1'b1) stalls++;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// Two bytes make a word; ready must come exactly when out of reset.
	task automatic word(input logic rd, input logic [1:0] sel, input logic [15:0] w);
		logic [7:0] b0, b1;
		logic       ok0, ok1;
		host.xfer(rd, sel, 1'b0, byte_order_select ? w[15:8] : w[7:0], b0, ok0);
		host.xfer(rd, sel, 1'b1, byte_order_select ? w[7:0] : w[15:8], b1, ok1);
		rv = byte_order_select ? {b0, b1} : {b1, b0};
		check("ready", {15'h0000, ok0 & ok1}, {15'h0000, !rst_i});
		if ((ok0 & ok1) !== !rst_i)
			summarize();
	endtask : word
	task automatic core_write(input logic [15:0] v);
		@(posedge clock_i);
		core_reg_wr_i <= 1'b1;
		core_reg_wdata_i <= v;
		@(posedge clock_i);
		core_reg_wr_i <= 1'b0;
		// Let the register update settle before anyone looks at it.
		@(posedge clock_i);
	endtask : core_write
	// Reset, the row loop, then interrupts, a RAM clash and access during reset.
	initial begin
		{rst_i, data_strobe_b_n_i, addr_strobe_n_i, core_ram_valid_i} = 4'hf;
		{core_reg_wr_i, byte_order_select, mismatches, tests_run, stalls, writes} = 0;
		core_reg_wdata_i = 16'h0000;
		core_reg_addr_i = `HBP_CTRL_ADDR;
		core_ram_addr_i = 16'h00ff;
		ram_rdata_i = 16'h0000;
		rows[0] = '{1'b0, `HBP_SEL_DATA, 16'h0010, 16'h1234, 16'h0010};
		rows[1] = '{1'b1, `HBP_SEL_DATA, 16'h0011, 16'ha5c3, 16'h0011};
		rows[2] = '{1'b0, `HBP_SEL_DATA_INC, 16'h0020, 16'h00ff, 16'h0021};
		rows[3] = '{1'b1, `HBP_SEL_DATA_INC, 16'h00fe, 16'hff00, 16'h00ff};
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		foreach (rows[i]) begin
			core_write({15'h0000, rows[i].byte_order_select});
			byte_order_select = rows[i].byte_order_select;
			word(1'b0, `HBP_SEL_ADDR, rows[i].ptr);
			word(1'b0, rows[i].sel, rows[i].data);
			check("ram", mem[rows[i].ptr[7:0]], rows[i].data);
			word(1'b1, `HBP_SEL_ADDR, 16'h0000);
			check("pointer", rv, rows[i].next_ptr);
			word(1'b0, `HBP_SEL_ADDR, rows[i].ptr);
			word(1'b1, `HBP_SEL_DATA, 16'h0000);
			check("readback", rv, rows[i].data);
			word(1'b1, `HBP_SEL_CTRL, 16'h0000);
			check("ctrl_host", rv, {15'h0000, byte_order_select});
		end
		check("stalls_none", stalls[15:0], 16'h0000);
		$display("test rows done");
		word(1'b0, `HBP_SEL_CTRL, 16'h0005);
		check("core_irq_set", {15'h0000, core_irq_request_o}, 16'h0001);
		core_write(16'h0009);
		check("host_irq_set", {15'h0000, host_irq_out_o}, 16'h0001);
		word(1'b0, `HBP_SEL_CTRL, 16'h0009);
		check("host_irq_clear", {15'h0000, host_irq_out_o}, 16'h0000);
		$display("test irq done");
		core_ram_addr_i <= 16'h0050;
		stalls = 0;
		word(1'b0, `HBP_SEL_ADDR, 16'h0050);
		word(1'b0, `HBP_SEL_DATA, 16'hbeef);
		check("stalls_clash", stalls[15:0], 16'h0001);
		check("ram_clash", mem[8'h50], 16'hbeef);
		$display("test clash done");
		rst_i <= 1'b1;
		writes = 0;
		word(1'b0, `HBP_SEL_DATA, 16'hdead);
		check("reset_writes", writes[15:0], 16'h0000);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		check("ctrl_reset", core_reg_rdata_o, `HBP_CTRL_RESET);
		$display("test reset done");
		summarize();
	end
endmodule : hbp_host_port_tb
bind hbp_host_port hbp_host_port_props u_props (.*);

// ===== hbp_pkg.sv
/*
 * Types shared by the 8-bit host byte port.
 * Assumes hbp_cfg.svh is on the include path.
 */
package hbp_pkg;
	// Host pin group after synchronisation.
	typedef struct packed {
		logic       chip_select_n;
		logic       strobe_a_n;
		logic       strobe_b_n;
		logic       addr_strobe_n;
		logic       read_write;
		logic       byte_ident;
		logic [1:0] reg_select;
	} hbp_pins_t;

	// One internal RAM request from the port.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [15:0] data;
	} hbp_ram_req_t;

	// Port sequencer states, Gray coded along the path.
	typedef enum logic [1:0] {
		HBP_IDLE   = 2'b00,
		HBP_ACTIVE = 2'b01,
		HBP_RAM    = 2'b11,
		HBP_DONE   = 2'b10
	} hbp_state_t;
endpackage : hbp_pkg
